// ### hw/ssd_top.sv
// selcall and dtmf in-band tone generation and detection with apb registers
//
// Behaviour
// - tones only within 288 to 3000 hz
// - reset loads default set, host may rewrite
// - mode bit 10 selects selcall
// - detection runs alongside untouched voice path
// - interrupt on every tone start, stop, change
// - table entry n defines tone code n
// - scan from entry zero, first match, irq
// - host programs decoder bandwidth and threshold
// - code 1f null, separate unknown code
// - code 14 is repeat, reported as received
// - selcall code bits 4-0, level from control
// - table accepts other sets, zero means none
// - mode bit 9 selects dtmf
// - dtmf detect sets irq and overwrites status
// - dtmf digit from transmit bits 3-0
// - dtmf codes map to row/column pairs
// - single tone: low for 0-7, high otherwise
// - twist from bits 6,5, level from control
// - bit 7 mutes the dtmf generator
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
module ssd_top #(
    parameter int FW          = 12,
    parameter int DTMF_TOL_HZ = 20
) (
    // clock and reset
    input  wire logic          clock_i,
    input  wire logic          rst_n_i,
    // apb slave
    input  wire logic          psel_i,
    input  wire logic          penable_i,
    input  wire logic          pwrite_i,
    input  wire logic [7:0]    paddr_i,
    input  wire logic [31:0]   pwdata_i,
    output logic               pready_o,
    output logic [31:0]        prdata_o,
    output logic               pslverr_o,
    // tone measurement from the receive filter chain
    input  wire logic          meas_valid_i,
    input  wire logic [FW-1:0] meas_freq_i,
    input  wire logic [7:0]    meas_level_i,
    input  wire logic          dtmf_valid_i,
    input  wire logic [FW-1:0] dtmf_low_hz_i,
    input  wire logic [FW-1:0] dtmf_high_hz_i,
    input  wire logic [7:0]    dtmf_level_i,
    // voice samples
    input  wire logic [15:0]   voice_i,
    output logic [15:0]        voice_o,
    // tone generator controls
    output logic [FW-1:0]      tone_a_hz_o,
    output logic [FW-1:0]      tone_b_hz_o,
    output logic               tone_a_en_o,
    output logic               tone_b_en_o,
    output logic [4:0]         tone_level_o,
    output logic [1:0]         twist_o,
    // tone event level
    output logic               irq_o
);
    import ssd_pkg::*;

    // registers
    logic [15:0]   mode_q;          // operating mode
    logic [7:0]    txd_q;           // transmit code and options
    logic [4:0]    actl_q;          // tone level
    logic [15:0]   dcfg_q;          // [7:0] bandwidth, [15:8] threshold
    logic [15:0]   irq_q;           // sticky event bits
    logic [15:0]   stat_q;          // group and tone code
    logic [FW-1:0] tbl_q [16];      // selcall tone table
    logic [4:0]    sc_last_q;       // last reported selcall code
    logic          sc_wait_q;       // scan in flight
    // apb decode
    logic          acc_go;          // access phase, answer not yet given
    logic          wr_en;           // write completes this edge
    logic          sel_mode, sel_txd, sel_actl, sel_prog;
    logic          sel_dcfg, sel_irq, sel_stat, sel_hit;
    logic [31:0]   rd_mux;          // read data selection
    // programming
    logic [3:0]    prog_idx;        // table entry written
    logic [FW-1:0] prog_hz;         // new frequency
    logic          prog_ok;         // value in band or zero
    // scanner link
    logic          scan_start, scan_done, scan_hit;
    logic [3:0]    scan_idx, scan_code;
    // receive events
    logic          sc_en, dt_en;
    logic          sc_quiet;        // measurement below threshold
    logic [4:0]    sc_new;          // selcall code of this result
    logic          sc_evt;          // result finished this cycle
    logic          sc_change;       // selcall state changed
    logic [4:0]    dt_code;         // dtmf detector code
    logic          dt_change;       // dtmf state changed
    logic          tone_evt;        // any in-band event
    // transmit selection
    logic          tx_on, sc_tx, dt_tx;
    logic [4:0]    tx_code;
    logic [1:0]    dt_r, dt_c;
    logic [FW-1:0] sc_hz;
    logic [FW-1:0] a_hz_d, b_hz_d;
    logic          a_en_d, b_en_d;

    // distance test for dtmf matching
    function automatic logic near(input logic [FW-1:0] a,
                                  input logic [FW-1:0] b);
        logic [FW-1:0] d;
        d = (a > b) ? a - b : b - a;
        return d <= FW'(DTMF_TOL_HZ);
    endfunction : near

    // apb address decode, one wait state per transfer
    assign acc_go   = psel_i && penable_i && !pready_o;
    assign wr_en    = psel_i && penable_i && pready_o && pwrite_i;
    assign sel_mode = (paddr_i == ADR_MODE);
    assign sel_txd  = (paddr_i == ADR_TXD);
    assign sel_actl = (paddr_i == ADR_ACTL);
    assign sel_prog = (paddr_i == ADR_PROG);
    assign sel_dcfg = (paddr_i == ADR_DCFG);
    assign sel_irq  = (paddr_i == ADR_IRQ);
    assign sel_stat = (paddr_i == ADR_STAT);
    assign sel_hit  = sel_mode | sel_txd | sel_actl | sel_prog
                    | sel_dcfg | sel_irq | sel_stat;
    assign rd_mux   = sel_mode ? {16'h0000, mode_q} :
                      sel_txd  ? {24'h000000, txd_q} :
                      sel_actl ? {27'h0000000, actl_q} :
                      sel_dcfg ? {16'h0000, dcfg_q} :
                      sel_irq  ? {16'h0000, irq_q} :
                      sel_stat ? {16'h0000, stat_q} : 32'h00000000;

    // apb answer: pready one cycle into the access phase
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h00000000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= acc_go;
            prdata_o  <= (acc_go && !pwrite_i) ? rd_mux : 32'h00000000;
            pslverr_o <= acc_go && !sel_hit;
        end
    end

    // control registers
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            mode_q <= 16'h0000;
            txd_q  <= 8'h1f;
            actl_q <= 5'h00;
            dcfg_q <= DCFG_RST;
        end else if (wr_en) begin
            if (sel_mode) mode_q <= pwdata_i[15:0];
            if (sel_txd)  txd_q  <= pwdata_i[7:0];
            if (sel_actl) actl_q <= pwdata_i[4:0];
            if (sel_dcfg) dcfg_q <= pwdata_i[15:0];
        end
    end

    // out-of-band writes are ignored, zero allowed
    assign prog_idx = pwdata_i[PROG_IDX_LSB +: 4];
    assign prog_hz  = pwdata_i[FW-1:0];
    assign prog_ok  = (prog_hz == '0)
                    || (prog_hz >= BAND_MIN_HZ && prog_hz <= BAND_MAX_HZ);

    // default set at reset, entries rewritable
    // any standard set fits; zero entry is no tone
    for (genvar g = 0; g < 16; g++) begin : g_tbl
        always_ff @(posedge clock_i) begin
            if (!rst_n_i) begin
                tbl_q[g] <= TBL_RST[g];
            end else if (wr_en && sel_prog && prog_ok
                         && prog_idx == 4'(g)) begin
                tbl_q[g] <= prog_hz;
            end
        end
    end

    // receive enables; voice path is never gated by them
    // mode bit 10 selects selcall
    assign sc_en    = mode_q[MODE_SC_BIT];
    assign dt_en    = mode_q[MODE_DT_BIT];
    assign sc_quiet = meas_level_i < dcfg_q[15:8];
    // a loud measurement starts a table scan
    assign scan_start = sc_en && meas_valid_i && !sc_quiet && !sc_wait_q;

    // scanner index n reads entry n as code n
    ssd_scan #(
        .N  (16),
        .FW (FW)
    ) u_scan (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .start_i (scan_start),
        .freq_i  (meas_freq_i),
        .bw_i    ({{(FW-8){1'b0}}, dcfg_q[7:0]}),
        .index_o (scan_idx),
        .entry_i (tbl_q[scan_idx]),
        .done_o  (scan_done),
        .hit_o   (scan_hit),
        .code_o  (scan_code)
    );

    // quiet gives null, unmatched gives unknown
    // repeat tone code passes through as any code
    assign sc_evt    = (sc_en && meas_valid_i && sc_quiet && !sc_wait_q)
                     || scan_done;
    assign sc_new    = scan_done ? (scan_hit ? {1'b0, scan_code}
                                             : CODE_UNKNOWN) : CODE_NULL;
    // report only a start, stop or change
    assign sc_change = sc_evt && (sc_new != sc_last_q);

    // dtmf pair lookup against row/column tables
    always_comb begin
        dt_code = CODE_DT_NULL;
        for (int k = 15; k >= 0; k--) begin
            if (near(dtmf_low_hz_i, ROW_HZ[DT_ROW[k]])
                && near(dtmf_high_hz_i, COL_HZ[DT_COL[k]])) begin
                dt_code = 5'(k);
            end
        end
        if (dtmf_level_i < dcfg_q[15:8]) begin
            dt_code = CODE_DT_NULL;
        end
    end

    assign dt_change = dt_en && dtmf_valid_i
                     && ({GRP_DTMF, dt_code} != stat_q[15:8]);
    assign tone_evt  = sc_change || dt_change;

    // scan tracking and last selcall state
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            sc_wait_q <= 1'b0;
            sc_last_q <= CODE_NULL;
        end else begin
            sc_wait_q <= scan_start || (sc_wait_q && !scan_done);
            if (sc_evt) sc_last_q <= sc_new;
        end
    end

    // dtmf result overwrites any selcall code
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            stat_q <= STAT_RST;
        end else if (dt_change) begin
            stat_q <= {GRP_DTMF, dt_code, 8'h00};
        end else if (sc_change) begin
            stat_q <= {GRP_SELCALL, sc_new, 8'h00};
        end
    end

    // sticky status, write one clears, a new event wins
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            irq_q <= 16'h0000;
            irq_o <= 1'b0;
        end else begin
            if (wr_en && sel_irq) irq_q <= irq_q & ~pwdata_i[15:0];
            // tone state change raises the event bit
            if (tone_evt) irq_q[IRQ_TONE_BIT] <= 1'b1;
            irq_o <= tone_evt || (irq_q[IRQ_TONE_BIT]
                     && !(wr_en && sel_irq && pwdata_i[IRQ_TONE_BIT]));
        end
    end

    // voice passes through with fixed one-cycle delay
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            voice_o <= 16'h0000;
        end else begin
            voice_o <= voice_i;
        end
    end

    // transmit selection; selcall wins if the host sets both
    assign tx_on   = mode_q[MODE_TX_BIT];
    assign sc_tx   = tx_on && sc_en;
    assign dt_tx   = tx_on && dt_en && !sc_en;
    assign tx_code = txd_q[4:0];
    // selcall code from bits 4-0, table lookup
    assign sc_hz   = tbl_q[tx_code[3:0]];
    assign dt_r    = DT_ROW[tx_code[3:0]];
    assign dt_c    = DT_COL[tx_code[3:0]];

    // generator selection
    always_comb begin
        a_hz_d = '0;
        b_hz_d = '0;
        a_en_d = 1'b0;
        b_en_d = 1'b0;
        if (sc_tx) begin
            // codes above the table (null) emit nothing
            a_hz_d = sc_hz;
            a_en_d = !tx_code[4] && (sc_hz != '0);
        end else if (dt_tx) begin
            a_hz_d = ROW_HZ[dt_r];
            b_hz_d = COL_HZ[dt_c];
            // single tone picks low or high by code
            a_en_d = !txd_q[TXD_MUTE_BIT]
                   && (!txd_q[TXD_SINGLE_BIT] || !tx_code[3]);
            b_en_d = !txd_q[TXD_MUTE_BIT]
                   && (!txd_q[TXD_SINGLE_BIT] || tx_code[3]);
        end
    end

    // outputs follow held registers until rewritten
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            tone_a_hz_o  <= '0;
            tone_b_hz_o  <= '0;
            tone_a_en_o  <= 1'b0;
            tone_b_en_o  <= 1'b0;
            tone_level_o <= 5'h00;
            twist_o      <= 2'h0;
        end else begin
            tone_a_hz_o  <= a_hz_d;
            tone_b_hz_o  <= b_hz_d;
            tone_a_en_o  <= a_en_d;
            tone_b_en_o  <= b_en_d;
            // level from control, twist from bits 6,5
            tone_level_o <= (sc_tx || dt_tx) ? actl_q : 5'h00;
            twist_o      <= dt_tx ? txd_q[TXD_TWIST_LSB +: 2] : 2'h0;
        end
    end

    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_scan_req;
        scan_start;
    endsequence
    sequence s_scan_end;
        ##[1:17] scan_done;
    endsequence

    chk_mode_off_quiet: assert property (
        !(tx_on && (sc_en || dt_en)) |=> !tone_a_en_o && !tone_b_en_o)
        else $error("tone output active with no mode selected");
    chk_sc_mode_gen: assert property (
        sc_tx && !tx_code[4] && sc_hz != '0 |=> tone_a_en_o
        && tone_a_hz_o == $past(sc_hz))
        else $error("selcall tone not generated from table");
    chk_dtmf_mute: assert property (
        dt_tx && txd_q[TXD_MUTE_BIT] |=> !tone_a_en_o && !tone_b_en_o)
        else $error("dtmf output not muted");
    chk_single_low: assert property (
        dt_tx && !txd_q[TXD_MUTE_BIT] && txd_q[TXD_SINGLE_BIT]
        && !tx_code[3] |=> tone_a_en_o && !tone_b_en_o)
        else $error("single tone did not pick the low tone");
    chk_scan_bound: assert property (
        s_scan_req |-> s_scan_end)
        else $error("tone table scan did not finish");
    chk_change_irq: assert property (
        tone_evt |=> irq_q[IRQ_TONE_BIT] ##0 irq_o)
        else $error("tone change did not raise event");
    chk_null_code: assert property (
        sc_change && !scan_done && !dt_change
        |=> stat_q[12:8] == CODE_NULL)
        else $error("silence not reported as null code");
    chk_dtmf_group: assert property (
        dt_change |=> stat_q[15:13] == GRP_DTMF
        && stat_q[12:8] == $past(dt_code))
        else $error("dtmf code not placed in status");
    chk_band_guard: assert property (
        wr_en && sel_prog && !prog_ok
        |=> tbl_q[$past(prog_idx)] == $past(tbl_q[prog_idx]))
        else $error("out of band tone accepted");
    chk_voice_path: assert property (
        1'b1 |=> voice_o == $past(voice_i))
        else $error("voice path disturbed");
    chk_twist_level: assert property (
        dt_tx |=> twist_o == $past(txd_q[6:5])
        && tone_level_o == $past(actl_q))
        else $error("dtmf twist or level wrong");
    chk_sc_level: assert property (
        sc_tx |=> tone_level_o == $past(actl_q) && twist_o == 2'h0)
        else $error("selcall level wrong");
endmodule : ssd_top

// ### pkg/ssd_pkg.sv
// shared constants for the selcall / dtmf tone signalling block
package ssd_pkg;
    // apb register byte offsets
    localparam logic [7:0] ADR_MODE   = 8'h00; // operating_mode_register
    localparam logic [7:0] ADR_TXD    = 8'h04; // tx_data_zero_register
    localparam logic [7:0] ADR_ACTL   = 8'h08; // analogue_control_register
    localparam logic [7:0] ADR_PROG   = 8'h0c; // tone table programming
    localparam logic [7:0] ADR_DCFG   = 8'h10; // decoder bandwidth/threshold
    localparam logic [7:0] ADR_IRQ    = 8'h14; // interrupt_status_register
    localparam logic [7:0] ADR_STAT   = 8'h18; // aux_analogue_status_register
    // mode register bits
    localparam int MODE_TX_BIT = 0;
    localparam int MODE_DT_BIT = 9;
    localparam int MODE_SC_BIT = 10;
    // transmit data fields
    localparam int TXD_SINGLE_BIT = 4;
    localparam int TXD_TWIST_LSB  = 5;
    localparam int TXD_MUTE_BIT   = 7;
    // programming register fields
    localparam int PROG_IDX_LSB   = 16;
    // interrupt status bit for in-band tone events
    localparam int IRQ_TONE_BIT   = 3;
    // status code field positions
    localparam int STAT_CODE_LSB  = 8;
    localparam int STAT_GRP_LSB   = 13;
    // tone codes and groups
    localparam logic [4:0] CODE_NULL    = 5'h1f;
    localparam logic [4:0] CODE_UNKNOWN = 5'h1e;
    localparam logic [4:0] CODE_DT_NULL = 5'h10;
    localparam logic [2:0] GRP_SELCALL  = 3'h0;
    localparam logic [2:0] GRP_DTMF     = 3'h2;
    // operating band limits in hz
    localparam logic [11:0] BAND_MIN_HZ = 12'd288;
    localparam logic [11:0] BAND_MAX_HZ = 12'd3000;
    // reset values
    localparam logic [15:0] DCFG_RST = 16'h4014; // thr 0x40, bw 20 hz
    localparam logic [15:0] STAT_RST = {GRP_SELCALL, CODE_NULL, 8'h00};
    // default selcall tone set, entry n is tone code n
    localparam logic [11:0] TBL_RST [16] = '{
        12'd1981, 12'd1124, 12'd1197, 12'd1275, 12'd1358, 12'd1446,
        12'd1540, 12'd1640, 12'd1747, 12'd1860, 12'd2400, 12'd930,
        12'd2247, 12'd991,  12'd2110, 12'd1055};
    // dtmf row and column frequencies
    localparam logic [11:0] ROW_HZ [4] = '{12'd697, 12'd770, 12'd852, 12'd941};
    localparam logic [11:0] COL_HZ [4] = '{12'd1209, 12'd1336, 12'd1477,
                                           12'd1633};
    // dtmf code to row/column index
    localparam logic [1:0] DT_ROW [16] = '{2'd3, 2'd0, 2'd0, 2'd0, 2'd1, 2'd1,
        2'd1, 2'd2, 2'd2, 2'd2, 2'd3, 2'd3, 2'd3, 2'd0, 2'd1, 2'd2};
    localparam logic [1:0] DT_COL [16] = '{2'd3, 2'd0, 2'd1, 2'd2, 2'd0, 2'd1,
        2'd2, 2'd0, 2'd1, 2'd2, 2'd1, 2'd0, 2'd2, 2'd3, 2'd3, 2'd3};
    // scanner states
    typedef enum logic [0:0] {
        SCN_IDLE = 1'b0,
        SCN_RUN  = 1'b1
    } ssd_scan_t;
endpackage : ssd_pkg

// ### hw/ssd_scan.sv
// sequential first-match scanner over the selcall tone table
`timescale 1ns/100ps
module ssd_scan #(
    parameter int N  = 16,
    parameter int FW = 12
) (
    // clock and reset
    input  wire logic          clock_i,
    input  wire logic          rst_n_i,
    // request
    input  wire logic          start_i,
    input  wire logic [FW-1:0] freq_i,
    input  wire logic [FW-1:0] bw_i,
    // table access
    output logic [3:0]         index_o,
    input  wire logic [FW-1:0] entry_i,
    // result
    output logic               done_o,
    output logic               hit_o,
    output logic [3:0]         code_o
);
    import ssd_pkg::*;

    ssd_scan_t       state_q;  // idle or scanning
    logic [FW-1:0]   freq_q;   // frequency under test
    logic [FW-1:0]   diff;     // distance to current entry
    logic            match;    // current entry is within bandwidth
    logic            last;     // last entry reached

    // zero entries mean no tone and never match
    assign diff  = (entry_i > freq_q) ? entry_i - freq_q : freq_q - entry_i;
    assign match = (entry_i != '0) && (diff <= bw_i);
    assign last  = (index_o == 4'(N - 1));

    // one entry per cycle, lowest index wins
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_q <= SCN_IDLE;
            freq_q  <= '0;
            index_o <= 4'h0;
            done_o  <= 1'b0;
            hit_o   <= 1'b0;
            code_o  <= 4'h0;
        end else begin
            done_o <= 1'b0;
            case (state_q)
                SCN_IDLE: begin
                    if (start_i) begin
                        freq_q  <= freq_i;
                        index_o <= 4'h0;
                        state_q <= SCN_RUN;
                    end
                end
                SCN_RUN: begin
                    if (match || last) begin
                        done_o  <= 1'b1;
                        hit_o   <= match;
                        code_o  <= index_o;
                        state_q <= SCN_IDLE;
                    end else begin
                        index_o <= index_o + 4'h1;
                    end
                end
                default: state_q <= SCN_IDLE;
            endcase
        end
    end
endmodule : ssd_scan

// ### tb/ssd_meas_src.sv
// receive filter chain model: one measurement pulse per bench request
`timescale 1ns/100ps
module ssd_meas_src (
    // clock
    input  wire logic        clock_i,
    // requests from the bench
    input  wire logic        sc_go_i,
    input  wire logic        dt_go_i,
    input  wire logic [11:0] fa_i,
    input  wire logic [11:0] fb_i,
    input  wire logic [7:0]  lvl_i,
    // measurement lines towards the block
    output logic             sc_vld_o,
    output logic             dt_vld_o,
    output logic [11:0]      fa_o,
    output logic [11:0]      fb_o,
    output logic [7:0]       lvl_o
);
    // outside a pulse the data lines carry the inverse, so stale data
    // can never pass for a fresh measurement
    always_ff @(posedge clock_i) begin
        sc_vld_o <= sc_go_i;
        dt_vld_o <= dt_go_i;
        fa_o     <= (sc_go_i | dt_go_i) ? fa_i : ~fa_i;
        fb_o     <= dt_go_i ? fb_i : ~fb_i;
        lvl_o    <= (sc_go_i | dt_go_i) ? lvl_i : ~lvl_i;
    end
endmodule : ssd_meas_src

// ### tb/test_ssd_top.sv
// register-level test of the tone signalling block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    error_cnt++; $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module test_ssd_top;
    import ssd_pkg::*;
    logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, serr, pslverr, scv, dtv, sgo = 0, dgo = 0;
    logic [11:0] fa, fb, ta, tb, fai = 12'h0, fbi = 12'h0;
    logic [7:0] lv, lvi = 8'h00;
    logic [15:0] vin = 16'h0000, vout;
    logic ae, be, irq;
    logic [4:0] lvl;
    logic [1:0] tw;
    int error_cnt = 0, n_tests = 0;
    // 25 mhz clock
    initial forever #20 clock = ~clock;
    ssd_meas_src SRC (.clock_i(clock), .sc_go_i(sgo), .dt_go_i(dgo),
        .fa_i(fai), .fb_i(fbi), .lvl_i(lvi), .sc_vld_o(scv),
        .dt_vld_o(dtv), .fa_o(fa), .fb_o(fb), .lvl_o(lv));
    ssd_top DUT (.clock_i(clock), .rst_n_i(rst_n), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
        .pslverr_o(pslverr), .meas_valid_i(scv), .meas_freq_i(fa),
        .meas_level_i(lv), .dtmf_valid_i(dtv), .dtmf_low_hz_i(fa),
        .dtmf_high_hz_i(fb), .dtmf_level_i(lv), .voice_i(vin),
        .voice_o(vout), .tone_a_hz_o(ta), .tone_b_hz_o(tb),
        .tone_a_en_o(ae), .tone_b_en_o(be), .tone_level_o(lvl),
        .twist_o(tw), .irq_o(irq));
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    task automatic step(input int n);
        repeat (n) @(posedge clock);
    endtask : step
    // one apb transfer, entered and left just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        q = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 20) begin
            error_cnt++;
            results();
        end
        @(posedge clock);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK("rdata", e, q)
    endtask : rd
    // one measurement, then wait for the event and clear it
    task automatic meas(input logic d, input logic [11:0] f0,
                        input logic [11:0] f1, input logic [7:0] l,
                        input logic [31:0] e);
        int k;
        sgo <= ~d;
        dgo <= d;
        fai <= f0;
        fbi <= f1;
        lvi <= l;
        @(posedge clock);
        sgo <= 1'b0;
        dgo <= 1'b0;
        for (k = 0; k < 40 && irq !== 1'b1; k++) step(1);
        `CHK("irq_set", 1'b1, irq)
        if (k == 40) results();
        rd(ADR_STAT, e);
        apb(1'b1, ADR_IRQ, 32'h8);
        step(3);
        `CHK("irq_clr", 1'b0, irq)
    endtask : meas
    initial begin
        step(10);
        rst_n <= 1'b1;
        @(posedge clock);
        rd(ADR_STAT, 32'h1f00);
        rd(ADR_DCFG, 32'h4014);
        rd(ADR_PROG, 32'h0);
        rd(8'h1c, 32'h0);
        `CHK("slverr", 1'b1, serr)
        apb(1'b1, ADR_ACTL, 32'h15);
        apb(1'b1, ADR_TXD, 32'h1);
        // one in-band mode at a time
        apb(1'b1, ADR_MODE, 32'h401);
        step(3);
        `CHK("sc_tone", TBL_RST[1], ta)
        `CHK("sc_on", 1'b1, ae)
        `CHK("level", 5'h15, lvl)
        // block keeps programmed tones at 288 hz or above
        apb(1'b1, ADR_PROG, 32'h30000 | 32'd2000);
        apb(1'b1, ADR_PROG, 32'h30000 | 32'd100);
        apb(1'b1, ADR_TXD, 32'h3);
        step(3);
        `CHK("prog_tone", 12'd2000, ta)
        // host sends the repeat tone itself
        apb(1'b1, ADR_TXD, 32'he);
        step(3);
        `CHK("rpt_tone", TBL_RST[14], ta)
        apb(1'b1, ADR_TXD, 32'h1f);
        step(3);
        `CHK("null_off", 1'b0, ae)
        apb(1'b1, ADR_MODE, 32'h201);
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, ADR_TXD, c | (c[1:0] << 5));
            step(3);
            `CHK("dt_lo", ROW_HZ[DT_ROW[c]], ta)
            `CHK("dt_hi", COL_HZ[DT_COL[c]], tb)
            `CHK("twist", c[1:0], tw)
            apb(1'b1, ADR_TXD, c | 32'h10);
            step(3);
            `CHK("single", {c < 8, c >= 8}, {ae, be})
        end
        apb(1'b1, ADR_TXD, 32'h1);
        step(30);
        `CHK("hold", 2'b11, {ae, be})
        apb(1'b1, ADR_TXD, 32'h81);
        step(3);
        `CHK("mute", 2'b00, {ae, be})
        apb(1'b1, ADR_MODE, 32'h400);
        vin <= 16'ha5c3;
        meas(1'b0, 12'd1124, 12'd0, 8'h80, 32'h0100);
        `CHK("voice", 16'ha5c3, vout)
        meas(1'b0, 12'd500, 12'd0, 8'h80, 32'h1e00);
        meas(1'b0, 12'd1124, 12'd0, 8'h10, 32'h1f00);
        apb(1'b1, ADR_DCFG, 32'h2030);
        rd(ADR_DCFG, 32'h2030);
        meas(1'b0, 12'd1150, 12'd0, 8'h30, 32'h0100);
        apb(1'b1, ADR_MODE, 32'h200);
        meas(1'b1, 12'd697, 12'd1209, 8'h80, 32'h4100);
        results();
    end
endmodule : test_ssd_top
